// >>> mco_main_clock.v
`timescale 1ns/1ps
`include "mco_defs.vh"
module mco_main_clock
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire        i_soft_reset,
  // AXI4-Lite write
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  // AXI4-Lite read
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  // Clock sources, sampled on i_clk
  input  wire        i_monitor_slow_clock,
  input  wire        i_main_rc_clk,
  input  wire        i_ext_main_clk,
  input  wire        i_rc_stable_flag,
  input  wire [27:0] i_factory_trim,
  // Master clock coupling
  input  wire        i_mck_on_pll,
  output reg         o_mck_force_main,
  // Oscillator control
  output wire        o_xtal_osc_enable,
  output wire        o_xtal_bypass,
  output reg         o_main_src_active,
  output reg  [1:0]  o_main_rc_freq,
  output reg         o_main_clock_gate,
  output wire        o_rc2_enable,
  output wire [1:0]  o_rc2_freq_select,
  output reg  [1:0]  o_rc2_temp_trim,
  output reg  [2:0]  o_rc2_freq_trim,
  output wire        o_pll_a_ref_main,
  output wire        o_pll_b_ref_rc2,
  // Interrupt
  output wire        o_irq
);

  localparam S_IDLE    = 4'b0001;
  localparam S_FORCE   = 4'b0010;
  localparam S_SWITCH  = 4'b0100;
  localparam S_RESTORE = 4'b1000;

  // Byte-lane write merge
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    input [31:0] mask;
    reg   [31:0] m;
    begin
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
      wmerge = (old & ~m) | (data & m);
    end
  endfunction

  reg         rst_s1_reg;
  reg         rst_n;
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  reg  [31:0] main_osc_ctrl_reg;
  reg  [31:0] second_osc_ctrl_reg;
  reg  [31:0] second_rc_trim_reg;
  reg  [31:0] clock_irq_mask_reg;
  reg         counter_src_select;
  reg         switch_done_reg;
  reg  [3:0]  state_reg;
  reg  [3:0]  wait_reg;
  reg         slow_prev_reg;
  reg         rc_prev_reg;
  reg         ext_prev_reg;
  reg  [2:0]  slow_div_reg;
  reg         src_stable_prev_reg;
  wire        xtal_stable_flag;
  wire [15:0] measured_cycle_count;
  wire        measure_ready;

  // AXI handshakes
  wire wr_go = i_awvalid && i_wvalid && !o_bvalid;
  wire rd_go = i_arvalid && !o_rvalid;
  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign o_arready = rd_go;

  wire wr_moc  = wr_go && (i_awaddr == `MCO_OFF_MAIN_OSC_CTRL);
  wire wr_fcr  = wr_go && (i_awaddr == `MCO_OFF_FREQ_COUNTER);
  wire wr_msk  = wr_go && (i_awaddr == `MCO_OFF_CLOCK_IRQ_MASK);
  wire wr_soc  = wr_go && (i_awaddr == `MCO_OFF_SECOND_OSC_CTRL);
  wire wr_trim = wr_go && (i_awaddr == `MCO_OFF_SECOND_RC_TRIM);
  wire wr_ok   = wr_moc || wr_fcr || wr_msk || wr_soc || wr_trim ||
                 (wr_go && (i_awaddr == `MCO_OFF_CLOCK_STATUS));

  wire [31:0] moc_next = wmerge(main_osc_ctrl_reg, i_wdata, i_wstrb,
                                `MCO_MOC_MASK);
  wire        xtal_load = wr_moc && moc_next[`MCO_MOC_XTAL_EN] &&
                          i_wstrb[1];

  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_osc_ctrl_reg   <= 32'h00000000;
      second_osc_ctrl_reg <= `MCO_SOC_RESET;
      clock_irq_mask_reg  <= 32'h00000000;
      counter_src_select  <= 1'b0;
    end
    else
    begin
      if (wr_moc)
        main_osc_ctrl_reg <= moc_next;
      if (wr_soc)
        second_osc_ctrl_reg <= wmerge(second_osc_ctrl_reg, i_wdata, i_wstrb,
                                      `MCO_SOC_MASK);
      if (wr_msk)
        clock_irq_mask_reg <= wmerge(clock_irq_mask_reg, i_wdata, i_wstrb,
                                     `MCO_IRQ_MASK_BITS);
      if (wr_fcr && i_wstrb[3])
        counter_src_select <= i_wdata[`MCO_FCR_SRC_SEL];
    end
  end

  // Trim store, cleared by software reset as well
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      second_rc_trim_reg <= `MCO_TRIM_RESET;
    else if (i_soft_reset)
      second_rc_trim_reg <= `MCO_TRIM_RESET;
    else if (wr_trim && second_osc_ctrl_reg[`MCO_SOC_TRIM_WE])
      second_rc_trim_reg <= wmerge(second_rc_trim_reg, i_wdata, i_wstrb,
                                   32'hffffffff);
  end

  // Effective trim per option
  wire [27:0] eff_trim;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_trim
      assign eff_trim[g*7 +: 7] =
        second_rc_trim_reg[g*8 + `MCO_TRIM_SEL_BIT] ?
        second_rc_trim_reg[g*8 +: 7] : i_factory_trim[g*7 +: 7];
    end
  endgenerate

  wire [6:0] cur_trim = eff_trim[o_rc2_freq_select*7 +: 7];
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rc2_temp_trim <= 2'h0;
      o_rc2_freq_trim <= 3'h0;
    end
    else
    begin
      o_rc2_temp_trim <= cur_trim[1:0];
      o_rc2_freq_trim <= cur_trim[4:2];
    end
  end

  assign o_xtal_osc_enable = main_osc_ctrl_reg[`MCO_MOC_XTAL_EN];
  assign o_xtal_bypass     = main_osc_ctrl_reg[`MCO_MOC_XTAL_BYPASS];
  assign o_rc2_enable      = second_osc_ctrl_reg[`MCO_SOC_RC2_EN];
  assign o_rc2_freq_select = second_osc_ctrl_reg[`MCO_SOC_FREQ_HI:
                                                 `MCO_SOC_FREQ_LO];
  assign o_pll_a_ref_main  = 1'b1;
  assign o_pll_b_ref_rc2   = second_osc_ctrl_reg[`MCO_SOC_PLLB_RC2];

  // Edge detection and slow/8 divider
  wire slow_fall = slow_prev_reg && !i_monitor_slow_clock;
  wire src_edge  = counter_src_select ? (i_ext_main_clk && !ext_prev_reg)
                                      : (i_main_rc_clk && !rc_prev_reg);
  wire tick8     = slow_fall && (slow_div_reg == `MCO_SLOW_DIV);
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slow_prev_reg <= 1'b0;
      rc_prev_reg   <= 1'b0;
      ext_prev_reg  <= 1'b0;
      slow_div_reg  <= 3'h0;
    end
    else
    begin
      slow_prev_reg <= i_monitor_slow_clock;
      rc_prev_reg   <= i_main_rc_clk;
      ext_prev_reg  <= i_ext_main_clk;
      if (slow_fall)
        slow_div_reg <= slow_div_reg + 3'h1;
    end
  end

  mco_xtal_startup u_xtal
  (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_tick8   (tick8),
    .i_enable  (o_xtal_osc_enable),
    .i_load    (xtal_load),
    .i_startup (moc_next[`MCO_MOC_STARTUP_HI:`MCO_MOC_STARTUP_LO]),
    .o_stable  (xtal_stable_flag)
  );

  // Source switch sequence
  wire [1:0] rc_freq_req = main_osc_ctrl_reg[`MCO_MOC_RC_FREQ_HI:
                                             `MCO_MOC_RC_FREQ_LO];
  wire sw_req = (main_osc_ctrl_reg[`MCO_MOC_SRC_SEL] != o_main_src_active) ||
                (rc_freq_req != o_main_rc_freq);
  wire sw_commit = (state_reg == S_SWITCH) && (wait_reg == 4'h0);
  wire sw_finish = (state_reg == S_RESTORE);
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg         <= S_IDLE;
      wait_reg          <= 4'h0;
      o_mck_force_main  <= 1'b0;
      o_main_src_active <= 1'b0;
      o_main_rc_freq    <= 2'h0;
      o_main_clock_gate <= 1'b1;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
          if (sw_req)
          begin
            o_mck_force_main <= i_mck_on_pll;
            wait_reg         <= i_mck_on_pll ? `MCO_FORCE_CYC : 4'h0;
            state_reg        <= S_FORCE;
          end
        S_FORCE:
          if (wait_reg == 4'h0)
          begin
            o_main_clock_gate <= 1'b0;
            wait_reg          <= `MCO_SWITCH_CYC;
            state_reg         <= S_SWITCH;
          end
          else
            wait_reg <= wait_reg - 4'h1;
        S_SWITCH:
          if (wait_reg == 4'h0)
          begin
            o_main_src_active <= main_osc_ctrl_reg[`MCO_MOC_SRC_SEL];
            o_main_rc_freq    <= rc_freq_req;
            o_main_clock_gate <= 1'b1;
            state_reg         <= S_RESTORE;
          end
          else
            wait_reg <= wait_reg - 4'h1;
        S_RESTORE:
        begin
          o_mck_force_main <= 1'b0;
          state_reg        <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // Done flag: hardware set wins over a new request clearing it
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      switch_done_reg <= 1'b0;
    else if (sw_finish)
      switch_done_reg <= 1'b1;
    else if ((state_reg == S_IDLE) && sw_req)
      switch_done_reg <= 1'b0;
  end

  // Measurement start causes
  wire src_stable = o_main_src_active ? xtal_stable_flag : i_rc_stable_flag;
  wire meas_start = (wr_fcr && i_wstrb[2] && i_wdata[`MCO_FCR_START]) ||
                    (src_stable && !src_stable_prev_reg) ||
                    sw_commit;
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      src_stable_prev_reg <= 1'b0;
    else
      src_stable_prev_reg <= src_stable;
  end

  mco_freq_counter u_meas
  (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_start     (meas_start),
    .i_slow_fall (slow_fall),
    .i_src_edge  (src_edge),
    .o_count     (measured_cycle_count),
    .o_ready     (measure_ready)
  );

  wire [31:0] status = {28'h0000000, measure_ready, switch_done_reg,
                        i_rc_stable_flag, xtal_stable_flag};
  assign o_irq = |(status & clock_irq_mask_reg);

  // Write response
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= 2'h0;
    end
    else if (wr_go)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_ok ? 2'h0 : 2'h2;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // Read response
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rvalid <= 1'b0;
      o_rresp  <= 2'h0;
      o_rdata  <= 32'h00000000;
    end
    else if (rd_go)
    begin
      o_rvalid <= 1'b1;
      o_rresp  <= 2'h0;
      if (i_araddr == `MCO_OFF_MAIN_OSC_CTRL)
        o_rdata <= main_osc_ctrl_reg;
      else if (i_araddr == `MCO_OFF_FREQ_COUNTER)
        o_rdata <= {7'h00, counter_src_select, 7'h00, measure_ready,
                    measured_cycle_count};
      else if (i_araddr == `MCO_OFF_CLOCK_STATUS)
        o_rdata <= status;
      else if (i_araddr == `MCO_OFF_CLOCK_IRQ_MASK)
        o_rdata <= clock_irq_mask_reg;
      else if (i_araddr == `MCO_OFF_SECOND_OSC_CTRL)
        o_rdata <= second_osc_ctrl_reg;
      else if (i_araddr == `MCO_OFF_SECOND_RC_TRIM)
        o_rdata <= second_rc_trim_reg;
      else
      begin
        o_rdata <= 32'h00000000;
        o_rresp <= 2'h2;
      end
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end

endmodule // mco_main_clock

// >>> mco_defs.vh
`ifndef MCO_DEFS_VH
`define MCO_DEFS_VH

// Register byte offsets
`define MCO_OFF_MAIN_OSC_CTRL   8'h00
`define MCO_OFF_FREQ_COUNTER    8'h04
`define MCO_OFF_CLOCK_STATUS    8'h08
`define MCO_OFF_CLOCK_IRQ_MASK  8'h0c
`define MCO_OFF_SECOND_OSC_CTRL 8'h10
`define MCO_OFF_SECOND_RC_TRIM  8'h14

// main_osc_ctrl_reg fields
`define MCO_MOC_XTAL_EN      0
`define MCO_MOC_XTAL_BYPASS  1
`define MCO_MOC_SRC_SEL      2
`define MCO_MOC_RC_FREQ_LO   4
`define MCO_MOC_RC_FREQ_HI   5
`define MCO_MOC_STARTUP_LO   8
`define MCO_MOC_STARTUP_HI   15
`define MCO_MOC_MASK         32'h0000ff37

// freq_counter_reg fields
`define MCO_FCR_COUNT_HI     15
`define MCO_FCR_READY        16
`define MCO_FCR_START        20
`define MCO_FCR_SRC_SEL      24

// clock_status_reg and clock_irq_mask_reg fields
`define MCO_ST_XTAL_STABLE   0
`define MCO_ST_RC_STABLE     1
`define MCO_ST_SWITCH_DONE   2
`define MCO_ST_MEAS_READY    3
`define MCO_IRQ_MASK_BITS    32'h00000005

// second_osc_ctrl_reg fields
`define MCO_SOC_RC2_EN       0
`define MCO_SOC_FREQ_LO      1
`define MCO_SOC_FREQ_HI      2
`define MCO_SOC_TRIM_WE      8
`define MCO_SOC_PLLB_RC2     16
`define MCO_SOC_MASK         32'h00010107
`define MCO_SOC_RESET        32'h00000001

// second_rc_trim_reg: one byte per frequency option
`define MCO_TRIM_SEL_BIT     7
`define MCO_TRIM_RESET       32'h00000000

// Timing counts
`define MCO_SLOW_DIV         3'h7
`define MCO_STARTUP_SHIFT    5'h00
`define MCO_FORCE_CYC        4'h4
`define MCO_SWITCH_CYC       4'h8
`define MCO_MEAS_FALLS       5'h0f

`endif

// >>> mco_xtal_startup.v
`timescale 1ns/1ps
`include "mco_defs.vh"
module mco_xtal_startup
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Control
  input  wire        i_tick8,
  input  wire        i_enable,
  input  wire        i_load,
  input  wire [7:0]  i_startup,
  // Status
  output reg         o_stable
);

  reg  [15:0] cnt_reg;
  reg         run_reg;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg  <= 16'h0000;
      run_reg  <= 1'b0;
      o_stable <= 1'b0;
    end
    else if (i_load)
    begin
      // Load first: enable bit lands on this same edge
      // Units of slow/8 ticks: value * 256 slow periods
      cnt_reg  <= {3'h0, i_startup, `MCO_STARTUP_SHIFT};
      run_reg  <= 1'b1;
      o_stable <= 1'b0;
    end
    else if (!i_enable)
    begin
      cnt_reg  <= 16'h0000;
      run_reg  <= 1'b0;
      o_stable <= 1'b0;
    end
    else if (run_reg && i_tick8)
    begin
      if (cnt_reg == 16'h0000)
      begin
        run_reg  <= 1'b0;
        o_stable <= 1'b1;
      end
      else
      begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

endmodule // mco_xtal_startup

// >>> mco_freq_counter.v
`timescale 1ns/1ps
`include "mco_defs.vh"
module mco_freq_counter
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Events
  input  wire        i_start,
  input  wire        i_slow_fall,
  input  wire        i_src_edge,
  // Result
  output reg  [15:0] o_count,
  output reg         o_ready
);

  reg         run_reg;
  reg         open_reg;
  reg  [4:0]  falls_reg;
  reg  [15:0] acc_reg;
  wire [15:0] acc_next;

  assign acc_next = acc_reg + {15'h0000, i_src_edge};

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_reg   <= 1'b0;
      open_reg  <= 1'b0;
      falls_reg <= 5'h00;
      acc_reg   <= 16'h0000;
      o_count   <= 16'h0000;
      o_ready   <= 1'b0;
    end
    else if (i_start)
    begin
      run_reg   <= 1'b1;
      open_reg  <= 1'b0;
      falls_reg <= 5'h00;
      acc_reg   <= 16'h0000;
      o_ready   <= 1'b0;
    end
    else if (run_reg && !open_reg)
    begin
      // Window opens on a slow falling edge: whole periods only
      if (i_slow_fall)
        open_reg <= 1'b1;
    end
    else if (run_reg)
    begin
      acc_reg <= acc_next;
      if (i_slow_fall)
      begin
        if (falls_reg == `MCO_MEAS_FALLS)
        begin
          run_reg <= 1'b0;
          o_count <= acc_next;
          o_ready <= 1'b1;
        end
        else
        begin
          falls_reg <= falls_reg + 5'h01;
        end
      end
    end
  end

endmodule // mco_freq_counter

// >>> mco_xtal_src.sv
`timescale 1ns/1ps
module mco_xtal_src
#(
  parameter HALF = 5
)
(
  // Clock and oscillator controls
  input  wire i_clk,
  input  wire i_enable,
  input  wire i_bypass,
  // Clock toward the block
  output reg  o_clk
);
  integer n = 0;
  initial o_clk = 1'b0;
  // Crystal stands still while unpowered and not fed in bypass
  always @(posedge i_clk)
  begin
    n <= (n + 1) % HALF;
    if (!(i_enable || i_bypass))
      o_clk <= 1'b0;
    else if (n == 0)
      o_clk <= ~o_clk;
  end
endmodule // mco_xtal_src

// >>> mco_main_clock_chk.sv
`timescale 1ns/1ps
module mco_main_clock_chk
(
  input wire        i_clk,
  input wire        i_rstn,
  input wire [7:0]  i_awaddr,
  input wire        i_awvalid,
  input wire        o_awready,
  input wire        i_wvalid,
  input wire [1:0]  o_bresp,
  input wire        o_bvalid,
  input wire        i_bready,
  input wire [7:0]  i_araddr,
  input wire        i_arvalid,
  input wire        o_arready,
  input wire [31:0] o_rdata,
  input wire [1:0]  o_rresp,
  input wire        o_rvalid,
  input wire        i_rready,
  input wire        i_mck_on_pll,
  input wire        o_mck_force_main,
  input wire        o_xtal_osc_enable,
  input wire        o_main_src_active,
  input wire        o_main_clock_gate
);
  reg [1:0] rq;
  reg [7:0] aq;
  reg [7:0] wq;
  always @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      rq <= 2'b00;
    else
      rq <= {rq[0], 1'b1};
  always @(posedge i_clk)
  begin
    if (i_arvalid && o_arready)
      aq <= i_araddr;
    if (i_awvalid && o_awready)
      wq <= i_awaddr;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rq[1]);
  property p_wr_resp;
    i_awvalid && i_wvalid && o_awready |=> o_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
  property p_b_drop;
    o_bvalid && i_bready |=> !o_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("bvalid not released");
  property p_wr_err;
    $rose(o_bvalid) && wq > 8'h14 |-> o_bresp == 2'b10;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("bad write response");
  property p_rd_resp;
    i_arvalid && o_arready |=> o_rvalid && (aq > 8'h14 ?
      (o_rresp == 2'b10 && o_rdata == 32'h0) : o_rresp == 2'b00);
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("bad read response");
  property p_r_drop;
    o_rvalid && i_rready |=> !o_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("rvalid not released");
  property p_xtal_off;
    $rose(o_rvalid) && aq == 8'h08 && !$past(o_xtal_osc_enable, 2)
      |-> !o_rdata[0];
  endproperty
  a_xtal_off: assert property (p_xtal_off)
    else $error("stable while off");
  property p_gate_len;
    $fell(o_main_clock_gate) |-> !o_main_clock_gate[*8]
      ##[1:4] o_main_clock_gate;
  endproperty
  a_gate_len: assert property (p_gate_len)
    else $error("bad gate length");
  property p_commit;
    $changed(o_main_src_active) |-> $rose(o_main_clock_gate);
  endproperty
  a_commit: assert property (p_commit) else $error("source not gated");
  property p_force;
    !o_main_clock_gate && i_mck_on_pll |-> o_mck_force_main;
  endproperty
  a_force: assert property (p_force) else $error("master not on main");
  property p_restore;
    $rose(o_main_clock_gate) && o_mck_force_main |=> !o_mck_force_main;
  endproperty
  a_restore: assert property (p_restore)
    else $error("pll not restored");
  property p_reset;
    disable iff (1'b0) !rq[1] |-> !o_xtal_osc_enable && !o_main_src_active;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
endmodule // mco_main_clock_chk
bind mco_main_clock mco_main_clock_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .i_mck_on_pll(i_mck_on_pll),
  .o_mck_force_main(o_mck_force_main), .o_xtal_osc_enable(o_xtal_osc_enable),
  .o_main_src_active(o_main_src_active),
  .o_main_clock_gate(o_main_clock_gate));

// >>> main_clock_osc_control_test.sv
`timescale 1ns/1ps
module main_clock_osc_control_test;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         srst = 1'b0;
  reg  [7:0]  aw = 8'h00;
  reg         awv = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg  [3:0]  ws = 4'h0;
  reg         wv = 1'b0;
  reg  [7:0]  ar = 8'h00;
  reg         arv = 1'b0;
  reg         slow = 1'b0;
  reg         rc = 1'b0;
  reg         rcst = 1'b0;
  reg  [27:0] ft = 28'h0;
  reg         pll = 1'b0;
  wire        awr, wr_y, bv, arr, rv, xen, frc, act, gate, irq;
  wire        byp, r2e, pa, pb;
  wire [1:0]  br, rr, rcf, tt;
  wire [1:0]  r2f;
  wire [2:0]  fq;
  wire [31:0] rdat;
  wire        ext;
  integer     num_errors = 0;
  integer     checks_done = 0;
  integer     seed = 42399;
  integer     k, n, i;
  reg  [31:0] d, tr;
  reg  [15:0] prev;
  reg  [6:0]  b;
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    n <= n + 1;
    if (n % 20 == 0) slow <= ~slow;
    if (n % 4 == 0) rc <= ~rc;
  end
  mco_main_clock DUT (.i_clk(clk), .i_rstn(rstn), .i_soft_reset(srst),
    .i_awaddr(aw), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
    .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr_y), .o_bresp(br),
    .o_bvalid(bv), .i_bready(1'b1), .i_araddr(ar), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv),
    .i_rready(1'b1), .i_monitor_slow_clock(slow), .i_main_rc_clk(rc),
    .i_ext_main_clk(ext), .i_rc_stable_flag(rcst), .i_factory_trim(ft),
    .i_mck_on_pll(pll), .o_mck_force_main(frc), .o_xtal_osc_enable(xen),
    .o_xtal_bypass(byp), .o_main_src_active(act), .o_main_rc_freq(rcf),
    .o_main_clock_gate(gate), .o_rc2_enable(r2e), .o_rc2_freq_select(r2f),
    .o_rc2_temp_trim(tt), .o_rc2_freq_trim(fq), .o_pll_a_ref_main(pa),
    .o_pll_b_ref_rc2(pb), .o_irq(irq));
  mco_xtal_src #(.HALF(5)) u_xtal (.i_clk(clk), .i_enable(xen),
    .i_bypass(byp), .o_clk(ext));
  task print_verdict;
    begin
      if (num_errors == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Sampled edges may lose or gain one count
  task chk_near(input [63:0] nm, input integer e, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (^g === 1'bx || g + 1 < e || g > e + 1)
      begin
        num_errors = num_errors + 1;
        $display("ERROR %0s exp %0d got %0d", nm, e, g);
      end
    end
  endtask
  task wait_on(input c, input integer lim);
    begin
      if (k >= lim)
      begin
        num_errors = num_errors + 1;
        $display("ERROR wait exp 1 got 0");
        print_verdict;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [3:0] s, input [1:0] e);
    begin
      @(posedge clk);
      aw <= a;
      wd <= v;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      @(negedge clk);
      for (k = 0; k < 50 && (awr & wr_y) !== 1'b1; k = k + 1)
        @(negedge clk);
      wait_on(1'b1, 50);
      @(posedge clk);
      awv <= 1'b0;
      wv <= 1'b0;
      @(negedge clk);
      for (k = 0; k < 50 && bv !== 1'b1; k = k + 1)
        @(negedge clk);
      wait_on(1'b1, 50);
      chk("bresp", e, br);
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a, input [1:0] e, output [31:0] v);
    begin
      @(posedge clk);
      ar <= a;
      arv <= 1'b1;
      @(negedge clk);
      for (k = 0; k < 50 && arr !== 1'b1; k = k + 1)
        @(negedge clk);
      wait_on(1'b1, 50);
      @(posedge clk);
      arv <= 1'b0;
      @(negedge clk);
      for (k = 0; k < 50 && rv !== 1'b1; k = k + 1)
        @(negedge clk);
      wait_on(1'b1, 50);
      chk("rresp", e, rr);
      v = rdat;
      @(posedge clk);
    end
  endtask
  task poll(input [7:0] a, input integer bit_n, input integer lim);
    integer p;
    begin
      d = 32'h0;
      for (p = 0; p < lim && d[bit_n] !== 1'b1; p = p + 1)
        rd(a, 2'b00, d);
      k = p;
      wait_on(1'b1, lim);
    end
  endtask
  task sw(input s, input [1:0] f);
    begin
      for (k = 0; k < 100 && (act !== s || rcf !== f); k = k + 1)
        @(posedge clk);
      wait_on(1'b1, 100);
      repeat (2) @(posedge clk);
      rd(8'h08, 2'b00, d);
      chk("sw_done", 1, d[2]);
      chk("irq", 1, irq);
    end
  endtask
  initial
  begin
    n = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    ft <= $random(seed);
    pll <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, 2'b00, d);
    chk("mainctl", 0, d);
    rd(8'h14, 2'b00, d);
    chk("trim", 0, d);
    rcst <= 1'b1;
    poll(8'h04, 16, 400);
    chk_near("rc_cnt", 80, d[15:0]);
    prev = d[15:0];
    tr = ($random(seed) & 32'hff7fff00) | 32'h00008000;
    wr(8'h14, tr, 4'he, 2'b00);
    rd(8'h14, 2'b00, d);
    chk("trim_we0", 0, d);
    wr(8'h10, 32'h101, 4'hf, 2'b00);
    wr(8'h14, tr, 4'he, 2'b00);
    rd(8'h14, 2'b00, d);
    chk("trim_rb", tr, d);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h10, 32'h101 | (i << 1) | ((i & 1) << 16), 4'hf, 2'b00);
      repeat (3) @(posedge clk);
      b = tr[8*i+7] ? tr[8*i +: 7] : ft[7*i +: 7];
      chk("trim_out", {b[1:0], b[4:2]}, {tt, fq});
      chk("rc2_sel", {1'b1, i[1:0]}, {r2e, r2f});
      chk("pll_b", i & 1, pb);
    end
    chk("pll_a", 1, pa);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(8'h14, 2'b00, d);
    chk("trim_srst", 0, d);
    wr(8'h0c, 32'hffffffff, 4'hf, 2'b00);
    rd(8'h0c, 2'b00, d);
    chk("mask", 5, d);
    wr(8'h00, 32'h101, 4'h3, 2'b00);
    repeat (9600) @(posedge clk);
    rd(8'h08, 2'b00, d);
    chk("early", 0, d[0]);
    poll(8'h08, 0, 1000);
    chk("irq", 1, irq);
    wr(8'h04, 32'h01100000, 4'hc, 2'b00);
    rd(8'h04, 2'b00, d);
    chk("held", {1'b0, prev}, d[16:0]);
    poll(8'h04, 16, 400);
    chk_near("ext_cnt", 64, d[15:0]);
    wr(8'h00, 32'h5, 4'h1, 2'b00);
    sw(1'b1, 2'b00);
    poll(8'h04, 16, 400);
    chk_near("sw_cnt", 64, d[15:0]);
    wr(8'h0c, 32'h4, 4'hf, 2'b00);
    wr(8'h00, 32'h21, 4'h1, 2'b00);
    @(negedge clk);
    chk("irq_clr", 0, irq);
    sw(1'b0, 2'b10);
    wr(8'h00, 32'h23, 4'h1, 2'b00);
    wr(8'h00, 32'h22, 4'h1, 2'b00);
    chk("bypass", 1, byp);
    rd(8'h08, 2'b00, d);
    chk("xtal_off", 0, d[0]);
    wr(8'h40, 32'h1, 4'hf, 2'b10);
    rd(8'h40, 2'b10, d);
    chk("unmapped", 0, d);
    print_verdict;
  end
endmodule // main_clock_osc_control_test
